// File: design/rx_address_filter.sv
// receive address filter: unicast, hash multicast, broadcast, tag compare
// assumes a byte stream synchronous to I_CLOCK, first byte after a last byte
//
// The address-and-strobe port is this design's own decision.
`default_nettype none

module rx_address_filter (
  // clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RST_B,
  // register port
  input wire logic [4:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  // receive stream
  input wire logic I_RX_VALID,
  input wire logic [7:0] I_RX_DATA,
  input wire logic I_RX_LAST,
  // filter results
  output logic O_DONE,
  output logic O_UNI_HIT,
  output logic O_GROUP_HIT,
  output logic O_BCAST_HIT,
  output logic O_TAG_HIT,
  output logic O_LEN_OK,
  output logic O_FINAL_HIT
);

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic {ST_IDLE, ST_FRAME} rx_state_e;

  typedef struct packed {
    rx_state_e st;
    logic [10:0] cnt;
    logic [31:0] crc;
    logic uni_ok;
    logic bc_ok;
    logic grp_bit;
    logic [5:0] hash;
    logic [15:0] tag_rx;
    logic [7:0] rx_config;
    logic [7:0] mac_config;
    logic [7:0] tag_high;
    logic [7:0] tag_low;
    logic [5:0][7:0] station_bytes;
    logic [7:0][7:0] group_hash_bytes;
    logic [7:0] rdata;
    logic done;
    logic uni_hit;
    logic grp_hit;
    logic bc_hit;
    logic tag_hit;
    logic len_ok;
    logic final_hit;
  } filt_s;

  filt_s s_r;
  filt_s s_nxt;

  // lsb-first serial crc over one byte
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[31] ^ d[i]) begin
        r = {r[30:0], 1'b0} ^ rx_filter_pkg::CRC_POLY;
      end else begin
        r = {r[30:0], 1'b0};
      end
    end
    return r;
  endfunction : crc_byte

  // offset decode is shared by reads, writes and the read-back checks
  function automatic logic is_station(input logic [4:0] a);
    return (a >= rx_filter_pkg::OFS_STATION_0) &&
           (a < rx_filter_pkg::OFS_STATION_0 + rx_filter_pkg::NUM_STATION);
  endfunction : is_station

  function automatic logic is_hash(input logic [4:0] a);
    return (a >= rx_filter_pkg::OFS_HASH_0) &&
           (a < rx_filter_pkg::OFS_HASH_0 + rx_filter_pkg::NUM_HASH);
  endfunction : is_hash

  // slot inside a bank; only the low three bits can be in range
  function automatic logic [2:0] bank_slot(input logic [4:0] a, input logic [4:0] base);
    logic [4:0] d;
    d = a - base;
    return d[2:0];
  endfunction : bank_slot

  ////////////////////////////////////////////////////////////////////////////
  logic [10:0] idx;
  logic [11:0] len;
  logic [63:0] filt_bits;
  logic [11:0] len_max;
  logic dest_seen;
  logic tag_on;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.rdata = 8'h00;
    idx = (s_r.st == ST_IDLE) ? 11'h000 : s_r.cnt;
    len = {1'b0, idx} + 12'h001;
    filt_bits = s_r.group_hash_bytes;
    dest_seen = 1'b0;
    tag_on = s_r.mac_config[rx_filter_pkg::BIT_TAG_FILTER_ON];
    len_max = rx_filter_pkg::MAX_LEN_PLAIN;

    // register reads; unmapped offsets read zero
    if (I_RD) begin
      if (is_station(I_ADDR)) begin
        s_nxt.rdata = s_r.station_bytes[bank_slot(I_ADDR, rx_filter_pkg::OFS_STATION_0)];
      end else if (is_hash(I_ADDR)) begin
        s_nxt.rdata = s_r.group_hash_bytes[bank_slot(I_ADDR, rx_filter_pkg::OFS_HASH_0)];
      end else begin
        case (I_ADDR)
          rx_filter_pkg::OFS_RX_CONFIG: s_nxt.rdata = s_r.rx_config;
          rx_filter_pkg::OFS_MAC_CONFIG: s_nxt.rdata = s_r.mac_config;
          rx_filter_pkg::OFS_TAG_LOW: s_nxt.rdata = s_r.tag_low;
          rx_filter_pkg::OFS_TAG_HIGH: s_nxt.rdata = s_r.tag_high;
          rx_filter_pkg::OFS_STATUS: s_nxt.rdata = {2'b00, s_r.final_hit, s_r.len_ok,
                                                    s_r.tag_hit, s_r.bc_hit,
                                                    s_r.grp_hit, s_r.uni_hit};
          default: s_nxt.rdata = 8'h00;
        endcase
      end
    end

    // register writes
    if (I_WR) begin
      if (is_station(I_ADDR)) begin
        s_nxt.station_bytes[bank_slot(I_ADDR, rx_filter_pkg::OFS_STATION_0)] = I_WDATA;
      end else if (is_hash(I_ADDR)) begin
        s_nxt.group_hash_bytes[bank_slot(I_ADDR, rx_filter_pkg::OFS_HASH_0)] = I_WDATA;
      end else begin
        case (I_ADDR)
          rx_filter_pkg::OFS_RX_CONFIG: s_nxt.rx_config = I_WDATA;
          rx_filter_pkg::OFS_MAC_CONFIG: s_nxt.mac_config = I_WDATA;
          rx_filter_pkg::OFS_TAG_LOW: s_nxt.tag_low = I_WDATA;
          rx_filter_pkg::OFS_TAG_HIGH: s_nxt.tag_high = I_WDATA;
          default: s_nxt.rdata = s_nxt.rdata;
        endcase
      end
    end

    // receive stream; decision uses config as it stood before any same-cycle write
    if (I_RX_VALID) begin
      case (s_r.st)
        ST_IDLE, ST_FRAME: begin
          if (idx == 11'h000) begin
            s_nxt.crc = rx_filter_pkg::CRC_INIT;
            s_nxt.uni_ok = 1'b1;
            s_nxt.bc_ok = 1'b1;
            s_nxt.tag_rx = 16'h0000;
            s_nxt.grp_bit = I_RX_DATA[0];
          end
          if (idx < rx_filter_pkg::DEST_BYTES) begin
            s_nxt.uni_ok = s_nxt.uni_ok & (I_RX_DATA == s_r.station_bytes[idx[2:0]]);
            s_nxt.bc_ok = s_nxt.bc_ok & (I_RX_DATA == 8'hFF);
            s_nxt.crc = crc_byte(s_nxt.crc, I_RX_DATA);
          end
          if (idx == rx_filter_pkg::DEST_BYTES - 11'h001) begin
            s_nxt.hash = s_nxt.crc[31:26];
          end
          if (idx == rx_filter_pkg::TAG_HIGH_POS) begin
            s_nxt.tag_rx[15:8] = I_RX_DATA;
          end
          if (idx == rx_filter_pkg::TAG_LOW_POS) begin
            s_nxt.tag_rx[7:0] = I_RX_DATA;
          end
          s_nxt.cnt = (idx == rx_filter_pkg::CNT_MAX) ? idx : idx + 11'h001;
          s_nxt.st = ST_FRAME;
          if (I_RX_LAST) begin
            s_nxt.st = ST_IDLE;
            s_nxt.done = 1'b1;
            dest_seen = len >= {1'b0, rx_filter_pkg::DEST_BYTES};
            s_nxt.uni_hit = dest_seen & s_nxt.uni_ok;
            s_nxt.bc_hit = dest_seen & s_nxt.bc_ok;
            s_nxt.grp_hit = dest_seen & s_nxt.grp_bit & filt_bits[s_nxt.hash];
            s_nxt.tag_hit = (len > {1'b0, rx_filter_pkg::TAG_LOW_POS}) &
                            ((s_nxt.tag_rx == 16'h0000) |
                             (s_nxt.tag_rx == {s_r.tag_high, s_r.tag_low}));
            if (tag_on) begin
              len_max = rx_filter_pkg::MAX_LEN_TAGGED;
            end
            s_nxt.len_ok = len <= len_max;
            s_nxt.final_hit = s_nxt.len_ok & (~tag_on | s_nxt.tag_hit) &
              (s_r.rx_config[rx_filter_pkg::BIT_ACCEPT_ANY] | s_nxt.uni_hit |
               (s_nxt.grp_hit & s_r.rx_config[rx_filter_pkg::BIT_ACCEPT_GROUP]) |
               (s_nxt.bc_hit & s_r.rx_config[rx_filter_pkg::BIT_ACCEPT_ALL_ONES]));
          end
        end
        default: s_nxt.st = ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; reset loads constants only
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      s_r <= '0;
      s_r.rx_config <= rx_filter_pkg::RST_BYTE;
      s_r.mac_config <= rx_filter_pkg::RST_BYTE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign O_RDATA = s_r.rdata;
  assign O_DONE = s_r.done;
  assign O_UNI_HIT = s_r.uni_hit;
  assign O_GROUP_HIT = s_r.grp_hit;
  assign O_BCAST_HIT = s_r.bc_hit;
  assign O_TAG_HIT = s_r.tag_hit;
  assign O_LEN_OK = s_r.len_ok;
  assign O_FINAL_HIT = s_r.final_hit;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [31:0] crc_chk;
  logic [63:0] filt_chk;
  assign crc_chk = crc_byte(s_r.crc, I_RX_DATA);
  assign filt_chk = s_r.group_hash_bytes;

  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RST_B);

  // config checks look one cycle back: the decision reads the registers
  // as they stood before a write landing with the last byte

  uni_mismatch_a: assert property (
    O_DONE && O_BCAST_HIT && s_r.station_bytes != 48'hFFFFFFFFFFFF |-> !O_UNI_HIT)
    else $error("unicast hit on an address that differs from station");

  uni_clear_a: assert property (
    I_RX_VALID && idx < rx_filter_pkg::DEST_BYTES &&
      I_RX_DATA != s_r.station_bytes[idx[2:0]] |=> !s_r.uni_ok)
    else $error("differing destination byte did not clear unicast match");

  addr_short_a: assert property (
    O_DONE && s_r.cnt < rx_filter_pkg::DEST_BYTES |->
      !O_UNI_HIT && !O_GROUP_HIT && !O_BCAST_HIT)
    else $error("address match reported for a frame shorter than the address");

  uni_bit_order_a: assert property (
    O_DONE && O_UNI_HIT |-> s_r.grp_bit == s_r.station_bytes[0][0])
    else $error("first received bit not matched against station byte 0 bit 0");

  station_readback_a: assert property (
    I_RD && is_station(I_ADDR) |=>
      O_RDATA == $past(s_r.station_bytes[bank_slot(I_ADDR, rx_filter_pkg::OFS_STATION_0)]))
    else $error("station byte read back wrong");

  hash_latch_a: assert property (
    I_RX_VALID && s_r.st == ST_FRAME && s_r.cnt == 11'h005 |=> s_r.hash == $past(crc_chk[31:26]))
    else $error("hash index not latched from last address byte crc");

  hash_hold_a: assert property (
    !(I_RX_VALID && idx == rx_filter_pkg::DEST_BYTES - 11'h001) |=> $stable(s_r.hash))
    else $error("hash index moved outside the last address byte");

  group_select_a: assert property (
    O_DONE && O_GROUP_HIT |-> filt_chk[s_r.hash] && s_r.grp_bit)
    else $error("multicast hit without selected filter bit");

  hash_readback_a: assert property (
    I_RD && is_hash(I_ADDR) |=>
      O_RDATA == $past(s_r.group_hash_bytes[bank_slot(I_ADDR, rx_filter_pkg::OFS_HASH_0)]))
    else $error("hash filter byte read back wrong");

  group_first_bit_a: assert property (
    I_RX_VALID && idx == 11'h000 |=> s_r.grp_bit == $past(I_RX_DATA[0]))
    else $error("group flag not taken from the first received bit");

  bcast_group_a: assert property (
    O_DONE && O_BCAST_HIT |-> s_r.grp_bit && s_r.cnt >= 11'h006)
    else $error("broadcast hit without all-ones first bit");

  bcast_clear_a: assert property (
    I_RX_VALID && idx < rx_filter_pkg::DEST_BYTES && I_RX_DATA != 8'hFF |=>
      !s_r.bc_ok)
    else $error("non all-ones destination byte did not clear broadcast match");

  tag_high_pos_a: assert property (
    I_RX_VALID && idx == rx_filter_pkg::TAG_HIGH_POS |=>
      s_r.tag_rx[15:8] == $past(I_RX_DATA))
    else $error("tag high byte not taken from the thirteenth frame byte");

  tag_match_a: assert property (
    O_DONE && O_TAG_HIT |-> s_r.tag_rx == 16'h0000 ||
      s_r.tag_rx == {$past(s_r.tag_high), $past(s_r.tag_low)})
    else $error("tag hit on an identifier that differs from the registers");

  tag_short_a: assert property (
    O_DONE && s_r.cnt <= rx_filter_pkg::TAG_LOW_POS |-> !O_TAG_HIT)
    else $error("tag hit on a frame too short to carry a tag");

  tag_zero_a: assert property (
    O_DONE && s_r.tag_rx == 16'h0000 && s_r.cnt >= 11'h00E |-> O_TAG_HIT)
    else $error("zero tag identifier not passed");

  len_limit_a: assert property (
    O_DONE && O_FINAL_HIT |-> s_r.cnt <= rx_filter_pkg::MAX_LEN_TAGGED &&
      ($past(s_r.mac_config[0]) || s_r.cnt <= rx_filter_pkg::MAX_LEN_PLAIN))
    else $error("over-length frame accepted");

  len_short_a: assert property (
    O_DONE && s_r.cnt <= rx_filter_pkg::MAX_LEN_PLAIN |-> O_LEN_OK)
    else $error("frame within the plain limit flagged too long");

  final_len_a: assert property (
    O_DONE && !O_LEN_OK |-> !O_FINAL_HIT)
    else $error("too long frame accepted");

  final_cause_a: assert property (
    O_DONE && O_FINAL_HIT && !$past(s_r.rx_config[4]) |-> O_UNI_HIT ||
      (O_GROUP_HIT && $past(s_r.rx_config[3])) || (O_BCAST_HIT && $past(s_r.rx_config[2])))
    else $error("frame accepted without an enabled match");

  promisc_pass_a: assert property (
    O_DONE && O_LEN_OK && $past(s_r.rx_config[rx_filter_pkg::BIT_ACCEPT_ANY]) &&
      (!$past(s_r.mac_config[rx_filter_pkg::BIT_TAG_FILTER_ON]) || O_TAG_HIT) |-> O_FINAL_HIT)
    else $error("promiscuous mode rejected a good frame");

  tag_gate_a: assert property (
    O_DONE && $past(s_r.mac_config[0]) && !O_TAG_HIT |-> !O_FINAL_HIT)
    else $error("tag mismatch accepted with tag filtering on");

  config_readback_a: assert property (
    I_RD && I_ADDR == rx_filter_pkg::OFS_RX_CONFIG |=> O_RDATA == $past(s_r.rx_config))
    else $error("receive configuration read back wrong");

  mac_readback_a: assert property (
    I_RD && I_ADDR == rx_filter_pkg::OFS_MAC_CONFIG |=> O_RDATA == $past(s_r.mac_config))
    else $error("mac configuration read back wrong");

  done_pulse_a: assert property (
    I_RX_VALID && I_RX_LAST |=> O_DONE ##1 !O_DONE)
    else $error("result strobe not one cycle after last byte");

  done_only_last_a: assert property (
    !(I_RX_VALID && I_RX_LAST) |=> !O_DONE)
    else $error("result strobe without a last byte");

  result_hold_a: assert property (
    !O_DONE |->
      $stable({O_UNI_HIT, O_GROUP_HIT, O_BCAST_HIT, O_TAG_HIT, O_LEN_OK, O_FINAL_HIT}))
    else $error("results changed without the result strobe");

endmodule : rx_address_filter

`default_nettype wire

// File: design/rx_filter_pkg.sv
// constants for the receive address filter: register map, fields, limits
// assumes an 8-bit register port and a byte-wide receive stream
`default_nettype none

package rx_filter_pkg;
  // register offsets
  localparam logic [4:0] OFS_STATION_0 = 5'h01;
  localparam logic [4:0] OFS_RX_CONFIG = 5'h0C;
  localparam logic [4:0] OFS_HASH_0 = 5'h10;
  localparam logic [4:0] OFS_MAC_CONFIG = 5'h1B;
  localparam logic [4:0] OFS_TAG_LOW = 5'h1C;
  localparam logic [4:0] OFS_TAG_HIGH = 5'h1D;
  localparam logic [4:0] OFS_STATUS = 5'h1E;
  // bank sizes
  localparam logic [4:0] NUM_STATION = 5'h06;
  localparam logic [4:0] NUM_HASH = 5'h08;
  // field positions
  localparam int BIT_ACCEPT_ALL_ONES = 2;
  localparam int BIT_ACCEPT_GROUP = 3;
  localparam int BIT_ACCEPT_ANY = 4;
  localparam int BIT_TAG_FILTER_ON = 0;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // frame layout and limits
  localparam logic [10:0] DEST_BYTES = 11'h006;
  localparam logic [10:0] TAG_HIGH_POS = 11'h00C;
  localparam logic [10:0] TAG_LOW_POS = 11'h00D;
  localparam logic [11:0] MAX_LEN_PLAIN = 12'h5EE;
  localparam logic [11:0] MAX_LEN_TAGGED = 12'h5F2;
  localparam logic [10:0] CNT_MAX = 11'h7FF;
  // hash crc
  localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
endpackage : rx_filter_pkg

`default_nettype wire

// File: test/rx_stream_src.sv
// stand-in for the receive path from the phy: one byte per valid cycle
// assumes the bench fills frm, calls send, and calls idle once a burst is over
`default_nettype none
////////////////////////////////////////
module rx_stream_src (
  // clock
  input wire logic i_clk,
  // byte stream
  output logic o_valid,
  output logic [7:0] o_data,
  output logic o_last
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] frm [0:1535];
  initial begin
    o_valid = 1'b0;
    o_data = 8'hA5;
    o_last = 1'b0;
  end
  // byte 0 first, bit 0 of each byte is the first bit on the wire
  // slow mode leaves an idle cycle before every odd byte
  task automatic send(input int n, input bit slow);
    for (int i = 0; i < n; i++) begin
      if (slow && i[0]) begin
        @(posedge i_clk);
        o_valid <= 1'b0;
        o_last <= 1'b0;
        o_data <= ~o_data;
      end
      @(posedge i_clk);
      o_valid <= 1'b1;
      o_data <= frm[i];
      o_last <= (i == n - 1);
    end
  endtask : send
  // released data flips, so no stale byte looks valid
  task automatic idle();
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_last <= 1'b0;
    o_data <= ~o_data;
  endtask : idle
endmodule : rx_stream_src
`default_nettype wire

// File: test/test_rx_address_filter.sv
// bench for the receive address filter: registers, frames, results
// assumes rx_stream_src as the receive path and a 100 MHz clock
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
////////////////////////////////////////
module test_rx_address_filter;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, wr, rd, rd_prev;
  logic [4:0] addr;
  logic [7:0] wdata, exp_rd;
  logic [5:0] last_res, exp_res;
  logic [31:0] seed, m;
  logic [7:0] regs [0:31];
  logic [7:0] rq [$];
  logic [5:0] fq [$];
  wire logic valid, last, done;
  wire logic [7:0] rxd, rdata;
  wire logic [5:0] res;
  int miscompares, checked, cycles;
  rx_address_filter dut (.I_CLOCK(clk), .I_RST_B(rst_b), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_RX_VALID(valid), .I_RX_DATA(rxd),
    .I_RX_LAST(last), .O_DONE(done), .O_UNI_HIT(res[0]), .O_GROUP_HIT(res[1]),
    .O_BCAST_HIT(res[2]), .O_TAG_HIT(res[3]), .O_LEN_OK(res[4]), .O_FINAL_HIT(res[5]));
  rx_stream_src src (.i_clk(clk), .o_valid(valid), .o_data(rxd), .o_last(last));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic bit mapped(input logic [4:0] a);
    return (a >= 1 && a <= 6) || a == 12 || (a >= 16 && a <= 23) || (a >= 27 && a <= 30);
  endfunction : mapped
  task automatic final_report();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  // one strobe per call, back to back allowed; status place is read only
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= w;
    rd <= ~w;
    addr <= a;
    wdata <= d;
    if (w && mapped(a) && a != 5'h1E) regs[a] = d;
    if (!w) rq.push_back(mapped(a) ? (a == 5'h1E ? {2'b00, last_res} : regs[a]) : 8'h00);
  endtask : bus
  task automatic quiet();
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : quiet
  // expected results worked out from the shadow registers, then the frame goes out
  task automatic frame(input int n, input bit slow);
    logic [31:0] c;
    logic [7:0] hb;
    logic u, g, b, tg, lo, tn;
    c = rx_filter_pkg::CRC_INIT;
    u = (n >= 6);
    b = u;
    for (int i = 0; i < 48; i++) begin
      if (i % 8 == 0) begin
        u &= (src.frm[i / 8] == regs[1 + i / 8]);
        b &= (src.frm[i / 8] == 8'hFF);
      end
      c = {c[30:0], 1'b0} ^ ((c[31] ^ src.frm[i / 8][i % 8]) ? rx_filter_pkg::CRC_POLY : 32'h0);
    end
    hb = regs[16 + c[31:29]];
    g = (n >= 6) && src.frm[0][0] && hb[c[28:26]];
    tg = (n >= 14) && ({src.frm[12], src.frm[13]} == 16'h0000 ||
      {src.frm[12], src.frm[13]} == {regs[29], regs[28]});
    tn = regs[27][0];
    lo = n <= (tn ? rx_filter_pkg::MAX_LEN_TAGGED : rx_filter_pkg::MAX_LEN_PLAIN);
    last_res = {lo & (!tn | tg) & (regs[12][4] | u | g & regs[12][3] | b & regs[12][2]),
      lo, tg, b, g, u};
    fq.push_back(last_res);
    src.send(n, slow);
  endtask : frame
  // read data is checked in the cycle after the strobe, results during the done pulse
  always @(negedge clk) begin
    // pop once into a variable: the macro names its arguments twice
    if (rd_prev === 1'b1) begin
      exp_rd = (rq.size() > 0) ? rq.pop_front() : 'x;
      `CHK("read data", exp_rd, rdata)
    end
    if (done === 1'b1) begin
      exp_res = (fq.size() > 0) ? fq.pop_front() : 'x;
      `CHK("results", exp_res, res)
    end
    rd_prev = rd;
    cycles++;
    if (cycles > 20000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    seed = 32'h00006B04;
    rst_b = 1'b0;
    {wr, rd, rd_prev, addr, wdata, last_res} = '0;
    foreach (regs[i]) regs[i] = rx_filter_pkg::RST_BYTE;
    foreach (src.frm[i]) src.frm[i] = 8'(xs());
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 32; a++) bus(1'b0, a[4:0], 8'h00);
    for (int a = 0; a < 32; a++) begin
      bus(1'b1, a[4:0], 8'(xs()));
      bus(1'b0, a[4:0], 8'h00);
    end
    quiet();
    $display("test registers done");
    for (int k = 0; k < 24; k++) begin
      bus(1'b1, 5'h0C, 8'(xs()) & 8'h1C);
      bus(1'b1, 5'h1B, 8'(xs()) & 8'h01);
      bus(1'b1, 5'h10 + 5'(k % 8), 8'(xs()));
      quiet();
      m = xs();
      for (int i = 0; i < 6; i++) begin
        if (m[1:0] == 2'd0) src.frm[i] = regs[1 + i];
        if (m[1:0] == 2'd1) src.frm[i] = 8'hFF;
      end
      if (m[2]) {src.frm[12], src.frm[13]} = m[3] ? 16'h0000 : {regs[29], regs[28]};
      frame(14 + int'(m[9:4]), m[10]);
      src.idle();
      bus(1'b0, 5'h1E, 8'h00);
    end
    quiet();
    $display("test random frames done");
    // one differing byte, short frames, back to back
    for (int i = 0; i < 20; i++) src.frm[i] = i < 6 ? regs[1 + i] : 8'(xs());
    frame(20, 1'b0);
    frame(5, 1'b0);
    frame(13, 1'b0);
    for (int i = 0; i < 6; i++) begin
      src.frm[i] ^= 8'h80;
      frame(20, 1'b1);
      src.frm[i] ^= 8'h80;
    end
    src.idle();
    // every hash bit set to take all groups
    for (int i = 0; i < 8; i++) bus(1'b1, 5'h10 + i[4:0], 8'hFF);
    bus(1'b1, 5'h0C, 8'h08);
    // tag filter off, so group acceptance shows in the final result
    bus(1'b1, 5'h1B, 8'h00);
    quiet();
    for (int k = 0; k < 4; k++) begin
      src.frm[0] = {7'(xs()), k[0]};
      frame(30, 1'b0);
    end
    src.idle();
    $display("test directed frames done");
    // length limits either side of the bounds
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 5'h1B, {7'h00, k[0]});
      quiet();
      frame((k[0] ? 1522 : 1518) + k[1], 1'b0);
      src.idle();
    end
    repeat (4) @(posedge clk);
    bus(1'b0, 5'h1E, 8'h00);
    quiet();
    repeat (3) @(posedge clk);
    `CHK("frames left", 0, fq.size())
    $display("test lengths done");
    final_report();
  end
endmodule : test_rx_address_filter
`default_nettype wire
